// ===== ddrci_asserts.sv
// Link checks between the controller end and the device end
`default_nettype none
module ddrci_asserts #(parameter int POSTED_LAT = 1) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic ck,
	input wire logic clk_complement,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [1:0] bank_select,
	input wire logic [12:0] addr,
	input wire logic ctl_dq_oe,
	input wire logic dev_dq_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	import ddrci_pkg::*;
	localparam int RD_LO = 4 * (int'(CAS_LAT) + POSTED_LAT) - 1;
	localparam int RD_HI = RD_LO + 2;
	// Write enable rises three system cycles (three quarters of a link cycle) ahead of read enable
	localparam int WR_LO = RD_LO - 3;
	localparam int WR_HI = RD_HI - 3;
	logic [3:0] cmd;
	logic rise;
	logic ck_reg;
	logic [3:0] open_reg;
	logic [3:0] open_next;
	assign cmd = {cs_n, ras_n, cas_n, we_n};
	// Taken only where the link clock rises with clock enable high
	assign rise = ck && !ck_reg && cke;
	always_comb begin
		open_next = open_reg;
		if (rise && cmd == CMD_ACT)
			open_next[bank_select] = 1'h1;
		if (rise && (cmd == CMD_PRE || ((cmd == CMD_RD || cmd == CMD_WR) && addr[AP_BIT])))
			open_next[bank_select] = 1'h0;
	end
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			ck_reg <= 1'h0;
			open_reg <= 4'h0;
		end else begin
			ck_reg <= ck;
			open_reg <= open_next;
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	clk_pair_a: assert property (ck != clk_complement) else $error("clock pair not complementary");
	ck_rate_a: assert property ($rose(ck) |=> ck ##1 !ck [*2] ##1 ck) else $error("link clock rate wrong");
	cmd_setup_a: assert property ($changed(cmd) |-> !ck && !$past(ck)) else $error("command moved near rise");
	act_closed_a: assert property (rise && cmd == CMD_ACT |-> !open_reg[bank_select])
		else $error("activate to open bank");
	col_open_a: assert property (rise && (cmd == CMD_RD || cmd == CMD_WR) |-> open_reg[bank_select])
		else $error("column access to closed bank");
	pd_idle_a: assert property ($fell(cke) |-> open_reg == 4'h0) else $error("clock enable low with open bank");
	ref_idle_a: assert property (rise && cmd == CMD_REF |-> open_reg == 4'h0)
		else $error("refresh with open bank");
	wr_lat_a: assert property (rise && cmd == CMD_WR |-> ##[WR_LO:WR_HI] $rose(ctl_dq_oe))
		else $error("write data late or early");
	rd_lat_a: assert property (rise && cmd == CMD_RD |-> ##[RD_LO:RD_HI] $rose(dev_dq_oe))
		else $error("read data late or early");
endmodule : ddrci_asserts
`default_nettype wire

// ===== ddrci_controller.sv
// Memory controller end: link clock divider, command sequencing, refresh and read buffer
`default_nettype none
module ddrci_controller (
	input wire logic i_clk,
	input wire logic i_reset,
	ddrci_if.ctrl lk,
	input wire logic i_req_valid,
	output logic o_req_ready,
	input wire logic i_req_write,
	input wire logic [ddrci_pkg::BANK_W-1:0] i_req_bank,
	input wire logic [ddrci_pkg::ROW_W-1:0] i_req_row,
	input wire logic [ddrci_pkg::COL_W-1:0] i_req_col,
	input wire logic i_req_auto_pre,
	input wire logic [ddrci_pkg::BURST_W-1:0] i_req_wdata,
	input wire logic i_burst_len8,
	input wire logic [2:0] i_posted_extra_latency,
	input wire logic i_hot,
	input wire logic i_power_down,
	output logic o_powered_down,
	output logic o_rd_valid,
	input wire logic i_rd_ready,
	output logic [ddrci_pkg::BURST_W-1:0] o_rd_data
);
	import ddrci_pkg::*;

	logic tick;
	logic accept;
	logic col_go;
	logic [6:0] rl4;
	logic [6:0] wl4;
	logic [6:0] bl2;
	logic [6:0] wofs;
	logic [6:0] rofs;
	logic push;
	logic pop;
	logic ref_set;
	logic ref_clr;

	logic [1:0] ph_reg;
	logic ck_reg;
	logic ckc_reg;
	logic cke_reg, cke_next;
	logic [3:0] cmd_reg, cmd_next;
	logic [1:0] ba_reg, ba_next;
	logic [ROW_W-1:0] addr_reg, addr_next;
	logic [DQ_W-1:0] dqo_reg, dqo_next;
	logic dqoe_reg, dqoe_next;
	logic [DQ_W-1:0] dqs1_reg;
	logic [DQ_W-1:0] dqs2_reg;
	ddrci_ctl_st_t st_reg, st_next;
	logic [6:0] cnt_reg, cnt_next;
	logic [3:0] open_reg, open_next;
	logic [ROW_W-1:0] row_reg [NUM_BANKS];
	logic [ROW_W-1:0] row_next [NUM_BANKS];
	logic rq_wr_reg, rq_wr_next;
	logic [1:0] rq_bank_reg, rq_bank_next;
	logic [ROW_W-1:0] rq_row_reg, rq_row_next;
	logic [COL_W-1:0] rq_col_reg, rq_col_next;
	logic rq_ap_reg, rq_ap_next;
	logic [BURST_W-1:0] rq_data_reg, rq_data_next;
	logic rq_bl8_reg, rq_bl8_next;
	logic [3:0] rq_rl_reg, rq_rl_next;
	logic ready_reg, ready_next;
	logic [7:0] ref_cnt_reg, ref_cnt_next;
	logic ref_due_reg, ref_due_next;
	logic [BURST_W-1:0] fmem_reg [2];
	logic [BURST_W-1:0] fmem_next [2];
	logic fwp_reg, fwp_next;
	logic frp_reg, frp_next;
	logic [1:0] fcnt_reg, fcnt_next;

	// Link data passes two flops before use
	always_ff @(posedge i_clk) begin
		dqs1_reg <= lk.dq;
		dqs2_reg <= dqs1_reg;
	end

	// Commands change mid low phase, a quarter before the rising crossing
	assign tick = (ph_reg == 2'h0);
	assign accept = i_req_valid && ready_reg;
	assign rl4 = {1'b0, rq_rl_reg, 2'b00};
	assign wl4 = rl4 - 7'd4;
	assign bl2 = rq_bl8_reg ? 7'd16 : 7'd8;
	assign wofs = cnt_reg - wl4 - 7'd1;
	assign rofs = cnt_reg - rl4 - 7'd3;
	assign pop = (fcnt_reg != 2'h0) && i_rd_ready;
	// At or above, so a switch to the shorter interval cannot wrap the counter
	assign ref_set = (ref_cnt_reg >= ((i_hot ? REF_HOT_CYC : REF_NORMAL_CYC) - 8'h01));

	always_comb begin
		cke_next = cke_reg;
		cmd_next = tick ? CMD_NOP : cmd_reg;
		ba_next = ba_reg;
		addr_next = addr_reg;
		dqo_next = dqo_reg;
		dqoe_next = 1'b0;
		st_next = st_reg;
		cnt_next = cnt_reg;
		open_next = open_reg;
		row_next = row_reg;
		rq_wr_next = rq_wr_reg;
		rq_bank_next = rq_bank_reg;
		rq_row_next = rq_row_reg;
		rq_col_next = rq_col_reg;
		rq_ap_next = rq_ap_reg;
		rq_data_next = rq_data_reg;
		rq_bl8_next = rq_bl8_reg;
		rq_rl_next = rq_rl_reg;
		col_go = 1'b0;
		push = 1'b0;
		ref_clr = 1'b0;
		case (st_reg)
			CT_IDLE: begin
				if (tick && accept) begin
					rq_wr_next = i_req_write;
					rq_bank_next = i_req_bank;
					rq_row_next = i_req_row;
					rq_col_next = i_req_col;
					rq_ap_next = i_req_auto_pre;
					rq_data_next = i_req_write ? i_req_wdata : '0;
					rq_bl8_next = i_burst_len8;
					rq_rl_next = CAS_LAT + {1'b0, (i_posted_extra_latency > AL_MAX) ?
						AL_MAX : i_posted_extra_latency};
					ba_next = i_req_bank;
					if (open_reg[i_req_bank] && row_reg[i_req_bank] == i_req_row) begin
						cmd_next = i_req_write ? CMD_WR : CMD_RD;
						addr_next = {2'b00, i_req_auto_pre, i_req_col};
						st_next = CT_DATA;
						cnt_next = 7'd0;
						open_next[i_req_bank] = !i_req_auto_pre;
					end else if (open_reg[i_req_bank]) begin
						cmd_next = CMD_PRE;
						open_next[i_req_bank] = 1'b0;
						st_next = CT_ACT;
					end else begin
						cmd_next = CMD_ACT;
						addr_next = i_req_row;
						open_next[i_req_bank] = 1'b1;
						row_next[i_req_bank] = i_req_row;
						st_next = CT_COL;
					end
				end else if (tick && (ref_due_reg || i_power_down) && open_reg != 4'h0) begin
					// Banks close one per link cycle before refresh or power-down
					cmd_next = CMD_PRE;
					ba_next = first_open(open_reg);
					open_next[first_open(open_reg)] = 1'b0;
				end else if (tick && i_power_down) begin
					cke_next = 1'b0;
					st_next = CT_PD;
				end else if (tick && ref_due_reg) begin
					cmd_next = CMD_REF;
					ref_clr = 1'b1;
				end
			end
			CT_ACT: begin
				if (tick) begin
					cmd_next = CMD_ACT;
					addr_next = rq_row_reg;
					open_next[rq_bank_reg] = 1'b1;
					row_next[rq_bank_reg] = rq_row_reg;
					st_next = CT_COL;
				end
			end
			CT_COL: begin
				if (tick) begin
					cmd_next = rq_wr_reg ? CMD_WR : CMD_RD;
					addr_next = {2'b00, rq_ap_reg, rq_col_reg};
					open_next[rq_bank_reg] = !rq_ap_reg;
					st_next = CT_DATA;
					cnt_next = 7'd0;
				end
			end
			CT_DATA: begin
				cnt_next = (cnt_reg == 7'h7f) ? cnt_reg : cnt_reg + 7'd1;
				// Each beat is driven a quarter link cycle before its crossing
				if (rq_wr_reg && cnt_reg > wl4 && cnt_reg <= wl4 + bl2) begin
					dqoe_next = 1'b1;
					if (!wofs[0]) begin
						dqo_next = rq_data_reg[wofs[3:1] * DQ_W +: DQ_W];
					end
				end
				if (!rq_wr_reg && cnt_reg >= rl4 + 7'd3 && rofs < bl2 && !rofs[0]) begin
					rq_data_next[rofs[3:1] * DQ_W +: DQ_W] = dqs2_reg;
					push = (rofs + 7'd2 == bl2);
				end
				if (tick && cnt_reg >= rl4 + bl2 + 7'd4) begin
					st_next = CT_IDLE;
				end
			end
			CT_PD: begin
				if (tick && !i_power_down) begin
					cke_next = 1'b1;
					st_next = CT_IDLE;
				end
			end
			default: begin
				st_next = CT_IDLE;
			end
		endcase
		ready_next = (st_next == CT_IDLE) && (ph_reg == 2'h3) && !(ref_due_reg || ref_set) &&
			!i_power_down && (fcnt_reg != 2'h2) && !accept;
		ref_cnt_next = ref_set ? 8'h00 : ref_cnt_reg + 8'h01;
		ref_due_next = ref_set || (ref_due_reg && !ref_clr);
		// Whole read bursts buffered; a full buffer holds off new requests
		fmem_next = fmem_reg;
		fwp_next = fwp_reg ^ push;
		frp_next = frp_reg ^ pop;
		fcnt_next = fcnt_reg + {1'b0, push} - {1'b0, pop};
		if (push) begin
			fmem_next[fwp_reg] = rq_data_next;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			ph_reg <= 2'h0;
			ck_reg <= 1'b0;
			ckc_reg <= 1'b1;
			cke_reg <= 1'b1;
			cmd_reg <= CMD_NOP;
			ba_reg <= 2'h0;
			addr_reg <= '0;
			dqo_reg <= 16'h0000;
			dqoe_reg <= 1'b0;
			st_reg <= CT_IDLE;
			cnt_reg <= 7'd0;
			open_reg <= 4'h0;
			rq_wr_reg <= 1'b0;
			rq_ap_reg <= 1'b0;
			rq_bl8_reg <= 1'b0;
			rq_rl_reg <= CAS_LAT;
			ready_reg <= 1'b0;
			ref_cnt_reg <= 8'h00;
			ref_due_reg <= 1'b0;
			fwp_reg <= 1'b0;
			frp_reg <= 1'b0;
			fcnt_reg <= 2'h0;
		end else begin
			ph_reg <= ph_reg + 2'h1;
			ck_reg <= ph_reg[0] ^ ph_reg[1];
			ckc_reg <= !(ph_reg[0] ^ ph_reg[1]);
			cke_reg <= cke_next;
			cmd_reg <= cmd_next;
			ba_reg <= ba_next;
			addr_reg <= addr_next;
			dqo_reg <= dqo_next;
			dqoe_reg <= dqoe_next;
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			open_reg <= open_next;
			rq_wr_reg <= rq_wr_next;
			rq_ap_reg <= rq_ap_next;
			rq_bl8_reg <= rq_bl8_next;
			rq_rl_reg <= rq_rl_next;
			ready_reg <= ready_next;
			ref_cnt_reg <= ref_cnt_next;
			ref_due_reg <= ref_due_next;
			fwp_reg <= fwp_next;
			frp_reg <= frp_next;
			fcnt_reg <= fcnt_next;
		end
		row_reg <= row_next;
		rq_bank_reg <= rq_bank_next;
		rq_row_reg <= rq_row_next;
		rq_col_reg <= rq_col_next;
		rq_data_reg <= rq_data_next;
		fmem_reg <= fmem_next;
	end

	assign lk.ck = ck_reg;
	assign lk.clk_complement = ckc_reg;
	assign lk.cke = cke_reg;
	assign {lk.cs_n, lk.ras_n, lk.cas_n, lk.we_n} = cmd_reg;
	assign lk.bank_select = ba_reg;
	assign lk.addr = addr_reg;
	assign lk.ctl_dq_o = dqo_reg;
	assign lk.ctl_dq_oe = dqoe_reg;
	assign o_req_ready = ready_reg;
	assign o_powered_down = (st_reg == CT_PD);
	assign o_rd_valid = (fcnt_reg != 2'h0);
	assign o_rd_data = fmem_reg[frp_reg];
endmodule : ddrci_controller
`default_nettype wire

// ===== ddrci_device.sv
// DDR2 device end: command decode, banks, bursts and storage on the link clock
`default_nettype none
module ddrci_device (
	ddrci_if.dev lk,
	input wire logic i_reset,
	input wire logic i_burst_len8,
	input wire logic i_interleave,
	input wire logic [2:0] i_posted_extra_latency,
	output logic [3:0] o_bank_open,
	output logic o_power_down,
	output logic o_suspended
);
	import ddrci_pkg::*;

	logic [5:0] sync1_reg;
	logic [5:0] sync2_reg;
	logic rst;
	logic bl8_cfg;
	logic int_cfg;
	logic [2:0] al_cfg;
	logic [3:0] rl;
	logic [3:0] cmd;
	logic live;
	logic is_act;
	logic is_pre;
	logic is_rd;
	logic is_wr;
	logic [MEM_AW-1:0] a0;
	logic [MEM_AW-1:0] a1;
	logic mem_we;

	logic [DQ_W-1:0] mem [0:(1 << MEM_AW) - 1];
	logic cke_reg, cke_next;
	logic [3:0] open_reg, open_next;
	logic [ROW_W-1:0] row_reg [NUM_BANKS];
	logic [ROW_W-1:0] row_next [NUM_BANKS];
	ddrci_dev_st_t st_reg, st_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [1:0] pair_reg, pair_next;
	logic wr_reg, wr_next;
	logic ap_reg, ap_next;
	logic bl8_reg, bl8_next;
	logic int_reg, int_next;
	logic [1:0] bank_reg, bank_next;
	logic [MEM_ROW_BITS-1:0] mrow_reg, mrow_next;
	logic [COL_W-1:0] col_reg, col_next;
	logic [DQ_W-1:0] pos_reg, pos_next;
	logic [DQ_W-1:0] pend_reg, pend_next;
	logic oe_reg, oe_next;
	logic pd_reg, pd_next;
	logic susp_reg, susp_next;
	logic [DQ_W-1:0] neg_reg;
	logic [DQ_W-1:0] wr_lo_reg;

	// Reset and configuration arrive from another domain
	always_ff @(posedge lk.ck) begin
		sync1_reg <= {i_reset, i_burst_len8, i_interleave, i_posted_extra_latency};
		sync2_reg <= sync1_reg;
	end

	assign rst = sync2_reg[5];
	assign bl8_cfg = sync2_reg[4];
	assign int_cfg = sync2_reg[3];
	assign al_cfg = (sync2_reg[2:0] > AL_MAX) ? AL_MAX : sync2_reg[2:0];
	assign rl = CAS_LAT + {1'b0, al_cfg};

	// Commands count only while clock enable is high now and last cycle
	assign cmd = {lk.cs_n, lk.ras_n, lk.cas_n, lk.we_n};
	assign live = lk.cke && cke_reg;
	// Every code has cs_n low, so a high select never matches
	assign is_act = live && (cmd == CMD_ACT);
	assign is_pre = live && (cmd == CMD_PRE);
	assign is_rd = live && (cmd == CMD_RD);
	assign is_wr = live && (cmd == CMD_WR);

	// Storage keeps only the low row bits to stay small
	assign a0 = {bank_reg, mrow_reg, col_reg[9:3],
		burst_offset(col_reg[2:0], {pair_reg, 1'b0}, bl8_reg, int_reg)};
	assign a1 = {bank_reg, mrow_reg, col_reg[9:3],
		burst_offset(col_reg[2:0], {pair_reg, 1'b1}, bl8_reg, int_reg)};

	always_comb begin
		cke_next = lk.cke;
		open_next = open_reg;
		row_next = row_reg;
		st_next = st_reg;
		cnt_next = cnt_reg;
		pair_next = pair_reg;
		wr_next = wr_reg;
		ap_next = ap_reg;
		bl8_next = bl8_reg;
		int_next = int_reg;
		bank_next = bank_reg;
		mrow_next = mrow_reg;
		col_next = col_reg;
		pos_next = pos_reg;
		pend_next = pend_reg;
		oe_next = oe_reg;
		mem_we = 1'b0;
		pd_next = !lk.cke && (open_reg == 4'h0);
		susp_next = !lk.cke && (open_reg != 4'h0);
		if (cke_reg) begin
			oe_next = 1'b0;
			if (is_act && !open_reg[lk.bank_select]) begin
				open_next[lk.bank_select] = 1'b1;
				row_next[lk.bank_select] = lk.addr;
			end
			if (is_pre) begin
				open_next[lk.bank_select] = 1'b0;
			end
			case (st_reg)
				DV_IDLE: begin
					if ((is_rd || is_wr) && open_reg[lk.bank_select]) begin
						st_next = DV_WAIT;
						cnt_next = rl - 4'h2;
						pair_next = 2'h0;
						wr_next = is_wr;
						ap_next = lk.addr[AP_BIT];
						bl8_next = bl8_cfg;
						int_next = int_cfg;
						bank_next = lk.bank_select;
						mrow_next = row_reg[lk.bank_select][MEM_ROW_BITS-1:0];
						col_next = lk.addr[COL_W-1:0];
					end
				end
				DV_WAIT: begin
					cnt_next = cnt_reg - 4'h1;
					if (cnt_reg == 4'h0) begin
						st_next = DV_BURST;
					end
				end
				DV_BURST: begin
					// Write data lands half a link cycle before read data would
					mem_we = wr_reg;
					if (!wr_reg) begin
						pos_next = mem[a0];
						pend_next = mem[a1];
						oe_next = 1'b1;
					end
					pair_next = pair_reg + 2'h1;
					if (pair_reg == (bl8_reg ? 2'h3 : 2'h1)) begin
						st_next = DV_IDLE;
						if (ap_reg) begin
							open_next[bank_reg] = 1'b0;
						end
					end
				end
				default: begin
					st_next = DV_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge lk.ck) begin
		if (rst) begin
			cke_reg <= 1'b0;
			open_reg <= 4'h0;
			st_reg <= DV_IDLE;
			cnt_reg <= 4'h0;
			pair_reg <= 2'h0;
			wr_reg <= 1'b0;
			ap_reg <= 1'b0;
			bl8_reg <= 1'b0;
			int_reg <= 1'b0;
			bank_reg <= 2'h0;
			mrow_reg <= '0;
			col_reg <= '0;
			pos_reg <= 16'h0000;
			pend_reg <= 16'h0000;
			oe_reg <= 1'b0;
			pd_reg <= 1'b0;
			susp_reg <= 1'b0;
		end else begin
			cke_reg <= cke_next;
			open_reg <= open_next;
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			pair_reg <= pair_next;
			wr_reg <= wr_next;
			ap_reg <= ap_next;
			bl8_reg <= bl8_next;
			int_reg <= int_next;
			bank_reg <= bank_next;
			mrow_reg <= mrow_next;
			col_reg <= col_next;
			pos_reg <= pos_next;
			pend_reg <= pend_next;
			oe_reg <= oe_next;
			pd_reg <= pd_next;
			susp_reg <= susp_next;
		end
		row_reg <= row_next;
		if (mem_we && !rst) begin
			mem[a0] <= wr_lo_reg;
			mem[a1] <= lk.dq;
		end
	end

	// Falling crossing: second read beat out, first write beat in
	always_ff @(negedge lk.ck) begin
		neg_reg <= pend_reg;
		wr_lo_reg <= lk.dq;
	end

	// Output pair switches with the clock level
	assign lk.dev_dq_o = lk.ck ? pos_reg : neg_reg;
	assign lk.dev_dq_oe = oe_reg;
	assign o_bank_open = open_reg;
	assign o_power_down = pd_reg;
	assign o_suspended = susp_reg;
endmodule : ddrci_device
`default_nettype wire

// ===== ddrci_if.sv
// Link pins between the memory controller and the DDR2 device
`default_nettype none
interface ddrci_if;
	logic ck;
	logic clk_complement;
	logic cke;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [1:0] bank_select;
	logic [12:0] addr;
	logic [15:0] ctl_dq_o;
	logic ctl_dq_oe;
	logic [15:0] dev_dq_o;
	logic dev_dq_oe;
	logic [15:0] dq;

	// Resolved data wire; undriven bus reads as zero
	assign dq = dev_dq_oe ? dev_dq_o : (ctl_dq_oe ? ctl_dq_o : 16'h0000);

	modport ctrl (
		output ck, clk_complement, cke, cs_n, ras_n, cas_n, we_n, bank_select, addr,
		output ctl_dq_o, ctl_dq_oe,
		input dq
	);
	modport dev (
		input ck, clk_complement, cke, cs_n, ras_n, cas_n, we_n, bank_select, addr,
		output dev_dq_o, dev_dq_oe,
		input dq
	);
endinterface : ddrci_if
`default_nettype wire

// ===== ddrci_pkg.sv
// Shared constants, types and helpers for the DDR2 command interface
`default_nettype none
package ddrci_pkg;
	localparam int ROW_W = 13;
	localparam int COL_W = 10;
	localparam int BANK_W = 2;
	localparam int NUM_BANKS = 4;
	localparam int DQ_W = 16;
	localparam int BL_MAX = 8;
	localparam int BURST_W = DQ_W * BL_MAX;
	localparam int AP_BIT = 10;
	localparam int MEM_ROW_BITS = 2;
	localparam int MEM_AW = BANK_W + MEM_ROW_BITS + COL_W;
	localparam logic [3:0] CAS_LAT = 4'h5;
	localparam logic [2:0] AL_MAX = 3'h6;
	localparam int CLK_NS = 40;
	localparam int REF_NORMAL_NS = 7800;
	localparam int REF_HOT_NS = 3900;
	localparam logic [7:0] REF_NORMAL_CYC = 8'(REF_NORMAL_NS / CLK_NS);
	localparam logic [7:0] REF_HOT_CYC = 8'(REF_HOT_NS / CLK_NS);
	// Command codes as {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_RD = 4'h5;
	localparam logic [3:0] CMD_WR = 4'h4;
	localparam logic [3:0] CMD_REF = 4'h1;

	typedef enum logic [1:0] {
		DV_IDLE = 2'b00,
		DV_WAIT = 2'b01,
		DV_BURST = 2'b11
	} ddrci_dev_st_t;

	typedef enum logic [2:0] {
		CT_IDLE = 3'b000,
		CT_ACT = 3'b001,
		CT_COL = 3'b011,
		CT_DATA = 3'b010,
		CT_PD = 3'b110
	} ddrci_ctl_st_t;

	// Low column bits of beat number beat within a burst
	function automatic logic [2:0] burst_offset(input logic [2:0] start, input logic [2:0] beat,
		input logic bl8, input logic interleave);
		logic [2:0] r;
		r = interleave ? (start ^ beat) : 3'(start + beat);
		burst_offset = bl8 ? r : {start[2], r[1:0]};
	endfunction : burst_offset

	// Lowest open bank, used to close banks one at a time
	function automatic logic [1:0] first_open(input logic [3:0] open);
		first_open = open[0] ? 2'h0 : open[1] ? 2'h1 : open[2] ? 2'h2 : 2'h3;
	endfunction : first_open
endpackage : ddrci_pkg
`default_nettype wire

// ===== testbench.sv
// Bench joining the controller and the device across the link
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import ddrci_pkg::*;
	localparam logic [2:0] POSTED = 3'h1;
	localparam int RN = REF_NORMAL_NS / CLK_NS;
	localparam int RH = REF_HOT_NS / CLK_NS;
	localparam logic [BURST_W-1:0] DA = 128'h1707_1606_1505_1404_1303_1202_1101_1000;
	localparam logic [BURST_W-1:0] DB = ~DA;
	localparam logic [BURST_W-1:0] DC = {DA[63:0], DA[127:64]};
	logic clk = 1'h0;
	logic reset = 1'h1;
	logic dev_reset = 1'h1;
	logic valid = 1'h0;
	logic wr = 1'h0;
	logic [1:0] bank = 2'h0;
	logic [12:0] row = 13'h0000;
	logic [9:0] col = 10'h000;
	logic ap = 1'h0;
	logic [BURST_W-1:0] wdata = '0;
	logic bl8 = 1'h1;
	logic ilv = 1'h0;
	logic hot = 1'h0;
	logic pd = 1'h0;
	logic rd_ready = 1'h0;
	logic ready;
	logic pd_done;
	logic rd_valid;
	logic [BURST_W-1:0] rd_data;
	logic [3:0] bank_open;
	logic dev_pd;
	logic dev_susp;
	logic [3:0] link_cmd;
	int bad_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	int ref_last = 0;
	int ref_gap = 0;
	ddrci_if ddrci_if_i ();
	ddrci_controller ddrci_controller_i (.i_clk(clk), .i_reset(reset), .lk(ddrci_if_i.ctrl), .i_req_valid(valid),
		.o_req_ready(ready), .i_req_write(wr), .i_req_bank(bank), .i_req_row(row), .i_req_col(col),
		.i_req_auto_pre(ap), .i_req_wdata(wdata), .i_burst_len8(bl8), .i_posted_extra_latency(POSTED),
		.i_hot(hot), .i_power_down(pd), .o_powered_down(pd_done), .o_rd_valid(rd_valid),
		.i_rd_ready(rd_ready), .o_rd_data(rd_data));
	ddrci_device ddrci_device_i (.lk(ddrci_if_i.dev), .i_reset(dev_reset), .i_burst_len8(bl8), .i_interleave(ilv),
		.i_posted_extra_latency(POSTED), .o_bank_open(bank_open), .o_power_down(dev_pd), .o_suspended(dev_susp));
	ddrci_asserts #(.POSTED_LAT(int'(POSTED))) ddrci_asserts_i (.i_clk(clk), .i_reset(reset), .ck(ddrci_if_i.ck),
		.clk_complement(ddrci_if_i.clk_complement), .cke(ddrci_if_i.cke), .cs_n(ddrci_if_i.cs_n),
		.ras_n(ddrci_if_i.ras_n), .cas_n(ddrci_if_i.cas_n), .we_n(ddrci_if_i.we_n),
		.bank_select(ddrci_if_i.bank_select), .addr(ddrci_if_i.addr), .ctl_dq_oe(ddrci_if_i.ctl_dq_oe),
		.dev_dq_oe(ddrci_if_i.dev_dq_oe));
	assign link_cmd = {ddrci_if_i.cs_n, ddrci_if_i.ras_n, ddrci_if_i.cas_n, ddrci_if_i.we_n};
	always #20 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	// Spacing of refresh commands, in system clock cycles
	always @(posedge ddrci_if_i.ck) begin
		if (ddrci_if_i.cke === 1'h1 && link_cmd === CMD_REF) begin
			ref_gap = cyc - ref_last;
			ref_last = cyc;
		end
	end
	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	task automatic chk_vec(input logic [BURST_W-1:0] got, input logic [BURST_W-1:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL at %0t: burst %h, expected %h", $time, got, exp);
		end
	endtask : chk_vec
	task automatic chk_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL at %0t: flag %b, expected %b", $time, got, exp);
		end
	endtask : chk_bit
	// Expected packing when a burst of d, stored from column 0, is read from column s
	function automatic logic [BURST_W-1:0] order(input logic [BURST_W-1:0] d, input int s, input logic b8,
		input logic il);
		logic [BURST_W-1:0] r;
		int k;
		r = '0;
		for (int j = 0; j < (b8 ? 8 : 4); j++) begin
			k = il ? (s ^ j) : b8 ? ((s + j) % 8) : ((s & 4) | ((s + j) % 4));
			r[16 * j +: 16] = d[16 * k +: 16];
		end
		return r;
	endfunction : order
	task automatic send(input logic w, input logic [1:0] b, input logic [12:0] r, input logic [9:0] c,
		input logic a, input logic [BURST_W-1:0] d);
		int n;
		n = 0;
		@(negedge clk);
		valid = 1'h1;
		wr = w;
		bank = b;
		row = r;
		col = c;
		ap = a;
		wdata = d;
		// Ready looked at settled; the next rising edge takes the request
		while (ready !== 1'h1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		valid = 1'h0;
	endtask : send
	task automatic pop(output logic [BURST_W-1:0] got);
		int n;
		n = 0;
		while (rd_valid !== 1'h1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		got = rd_data;
		rd_ready = 1'h1;
		@(negedge clk);
		rd_ready = 1'h0;
	endtask : pop
	task automatic rd(input logic [1:0] b, input logic [12:0] r, input logic [9:0] c, input logic a,
		output logic [BURST_W-1:0] got);
		send(1'h0, b, r, c, a, '0);
		pop(got);
	endtask : rd
	// Both ends must see the same setting, so settle it while idle
	task automatic cfg(input logic b8, input logic il);
		@(negedge clk);
		bl8 = b8;
		ilv = il;
		repeat (40) @(negedge clk);
	endtask : cfg
	task automatic t_burst();
		logic [BURST_W-1:0] g;
		send(1'h1, 2'h0, 13'h0001, 10'h000, 1'h0, DA);
		rd(2'h0, 13'h0001, 10'h000, 1'h0, g);
		chk_vec(g, DA);
		rd(2'h0, 13'h0001, 10'h005, 1'h0, g);
		chk_vec(g, order(DA, 5, 1'h1, 1'h0));
		cfg(1'h1, 1'h1);
		rd(2'h0, 13'h0001, 10'h005, 1'h0, g);
		chk_vec(g, order(DA, 5, 1'h1, 1'h1));
		cfg(1'h0, 1'h0);
		rd(2'h0, 13'h0001, 10'h005, 1'h0, g);
		chk_vec(g, order(DA, 5, 1'h0, 1'h0));
		cfg(1'h1, 1'h0);
		$display("burst order test done");
	endtask : t_burst
	task automatic t_banks();
		logic [BURST_W-1:0] g;
		send(1'h1, 2'h1, 13'h0001, 10'h000, 1'h0, DB);
		send(1'h1, 2'h2, 13'h0001, 10'h000, 1'h0, DC);
		send(1'h1, 2'h1, 13'h0002, 10'h000, 1'h0, DA);
		rd(2'h1, 13'h0001, 10'h000, 1'h0, g);
		chk_vec(g, DB);
		rd(2'h2, 13'h0001, 10'h000, 1'h0, g);
		chk_vec(g, DC);
		rd(2'h1, 13'h0002, 10'h000, 1'h0, g);
		chk_vec(g, DA);
		$display("bank and row test done");
	endtask : t_banks
	task automatic t_autopre();
		logic [BURST_W-1:0] g;
		send(1'h1, 2'h3, 13'h0000, 10'h000, 1'h1, DC);
		rd(2'h3, 13'h0000, 10'h000, 1'h1, g);
		chk_vec(g, DC);
		chk_bit(bank_open[3], 1'h0);
		rd(2'h3, 13'h0000, 10'h000, 1'h0, g);
		chk_vec(g, DC);
		$display("auto precharge test done");
	endtask : t_autopre
	task automatic t_buffer();
		logic [BURST_W-1:0] g;
		int seen;
		seen = 0;
		send(1'h0, 2'h0, 13'h0001, 10'h000, 1'h0, '0);
		send(1'h0, 2'h1, 13'h0001, 10'h000, 1'h0, '0);
		repeat (150) begin
			@(negedge clk);
			if (ready === 1'h1)
				seen++;
		end
		chk_bit(seen == 0, 1'h1);
		pop(g);
		chk_vec(g, DA);
		pop(g);
		chk_vec(g, DB);
		$display("full buffer test done");
	endtask : t_buffer
	task automatic t_power();
		logic [BURST_W-1:0] g;
		int n;
		n = 0;
		@(negedge clk);
		pd = 1'h1;
		while (pd_done !== 1'h1 && n < 500) begin
			@(negedge clk);
			n++;
		end
		repeat (20) @(negedge clk);
		chk_bit(dev_pd, 1'h1);
		chk_bit(bank_open == 4'h0, 1'h1);
		chk_bit(ddrci_if_i.cke, 1'h0);
		chk_bit(dev_susp, 1'h0);
		pd = 1'h0;
		rd(2'h2, 13'h0001, 10'h000, 1'h0, g);
		chk_vec(g, DC);
		$display("power down test done");
	endtask : t_power
	task automatic t_refresh();
		// Three refresh periods, so the last gap is free of precharge delay
		repeat (650) @(negedge clk);
		chk_bit(ref_gap >= RN - 4 && ref_gap <= RN + 4, 1'h1);
		hot = 1'h1;
		repeat (330) @(negedge clk);
		chk_bit(ref_gap >= RH - 4 && ref_gap <= RH + 4, 1'h1);
		$display("refresh interval test done");
	endtask : t_refresh
	initial begin
		repeat (3) @(negedge clk);
		reset = 1'h0;
		// Device flops run only once the link clock toggles
		repeat (24) @(negedge clk);
		dev_reset = 1'h0;
		repeat (8) @(negedge clk);
		t_burst();
		t_banks();
		t_autopre();
		t_buffer();
		t_power();
		t_refresh();
		conclude();
	end
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		$display("FAIL at %0t: run did not finish", $time);
		conclude();
	end
endmodule : testbench
`default_nettype wire
